// ==== hdl/scmc_pkg.sv ====
// Shared constants and types of the system clock and power-mode controller.
// Assumes an APB master with 32-bit data and word-aligned register slots.
package scmc_pkg;

  localparam int unsigned SCMC_ADDR_W = 12;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] SCMC_IDX_PWR = 8'h87;
  localparam logic [7:0] SCMC_IDX_CLK = 8'hD8;
  localparam logic [7:0] SCMC_IDX_AUXILIARY_CONTROL_TWO = 8'hF7;
  localparam logic [7:0] SCMC_IDX_CKOUT = 8'hF8;
  localparam logic [7:0] SCMC_IDX_STATUS = 8'hF9;

  localparam logic [7:0] SCMC_PWR_RESET = 8'h00;
  localparam logic [7:0] SCMC_PWR_WMASK = 8'h8F;
  localparam int unsigned SCMC_PWR_IDLE_BIT = 0;
  localparam int unsigned SCMC_PWR_STOP_BIT = 1;
  localparam logic [7:0] SCMC_CLK_RESET = 8'h03;
  localparam logic [7:0] SCMC_AUXILIARY_CONTROL_TWO_RESET = 8'h0E;
  localparam logic [7:0] SCMC_AUXILIARY_CONTROL_TWO_WMASK = 8'hFD;
  localparam logic [7:0] SCMC_CKOUT_RESET = 8'h00;

  localparam int unsigned SCMC_N_EXT = 3;
  localparam int unsigned SCMC_PSC_W = 4;
  localparam logic [3:0] SCMC_PSC_WINDOW = 4'hF;

  // Prescale codes and the last count of each division
  localparam logic [1:0] SCMC_PSC_DIV16 = 2'b00;
  localparam logic [1:0] SCMC_PSC_DIV4 = 2'b01;
  localparam logic [1:0] SCMC_PSC_DIV2 = 2'b10;
  localparam logic [1:0] SCMC_PSC_DIV1 = 2'b11;
  localparam logic [3:0] SCMC_LAST_DIV16 = 4'hF;
  localparam logic [3:0] SCMC_LAST_DIV4 = 4'h3;
  localparam logic [3:0] SCMC_LAST_DIV2 = 4'h1;
  localparam logic [3:0] SCMC_LAST_DIV1 = 4'h0;

  typedef struct packed {
    logic slow_clock_type_sel;
    logic fast_clock_type_sel;
    logic reserved;
    logic peripheral_clock_stop_idle;
    logic fast_clock_stop;
    logic system_clock_source_sel;
    logic [1:0] system_clock_prescale;
  } scmc_system_clock_control_t;

  typedef enum logic [1:0] {
    SCMC_RUN = 2'b00,
    SCMC_IDLE = 2'b01,
    SCMC_STOP = 2'b10
  } scmc_state_t;

  // Mode code reported in the status register
  typedef enum logic [1:0] {
    SCMC_MODE_SLOW = 2'b00,
    SCMC_MODE_FAST = 2'b01,
    SCMC_MODE_IDLE = 2'b10,
    SCMC_MODE_STOP = 2'b11
  } scmc_mode_t;

endpackage

// ==== hdl/scmc_sync.sv ====
// Two-flop synchroniser, one stage pair per bit.
// Assumes the inputs are asynchronous pins or oscillator levels.
`timescale 1ns/1ns
module scmc_sync #(
  parameter int unsigned WIDTH = 5
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  initial begin
    if (WIDTH < 1) begin
      $error("scmc_sync: WIDTH must be at least 1");
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        sync_out[i] <= meta_q;
      end
    end
  end
endmodule

// ==== hdl/scmc_prescaler.sv ====
// Divides source-clock ticks by 1, 2, 4 or 16 into system ticks.
// Assumes src_tick is a one-cycle pulse on pclk per source clock edge.
`timescale 1ns/1ns
module scmc_prescaler
  import scmc_pkg::*;
#(
  parameter int unsigned CNT_W = SCMC_PSC_W
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic src_tick, // one pulse per source clock
  input wire logic [1:0] psc_code, // requested prescale code
  output logic sys_tick_q // one pulse per system clock
);
  logic [CNT_W-1:0] phase_q;
  logic [CNT_W-1:0] div_q;
  logic [1:0] psc_eff_q;
  logic [CNT_W-1:0] last;

  initial begin
    if (CNT_W != SCMC_PSC_W) begin
      $error("scmc_prescaler: CNT_W must match the largest division");
    end
  end

  always_comb begin
    case (psc_eff_q)
      SCMC_PSC_DIV16: last = SCMC_LAST_DIV16;
      SCMC_PSC_DIV4: last = SCMC_LAST_DIV4;
      SCMC_PSC_DIV2: last = SCMC_LAST_DIV2;
      default: last = SCMC_LAST_DIV1;
    endcase
  end

  // New code is adopted only at the 16-tick window edge: glitch free, at most 16 ticks late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= '0;
      psc_eff_q <= SCMC_CLK_RESET[1:0];
    end else if (src_tick) begin
      phase_q <= phase_q + 1'b1;
      if (phase_q == SCMC_PSC_WINDOW) begin
        psc_eff_q <= psc_code;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      sys_tick_q <= 1'b0;
    end else begin
      sys_tick_q <= 1'b0;
      if (src_tick) begin
        if (div_q >= last) begin
          div_q <= '0;
          sys_tick_q <= 1'b1;
        end else begin
          div_q <= div_q + 1'b1;
        end
      end
    end
  end
endmodule

// ==== hdl/scmc_top.sv ====
// System clock source, prescale and power-mode controller with an APB register port.
// Assumes oscillator levels and wake pins are asynchronous; interrupt inputs are on pclk.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module scmc_top
  import scmc_pkg::*;
(
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [SCMC_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic fast_osc_in, // fast oscillator level
  input wire logic slow_osc_in, // slow oscillator level
  input wire logic [SCMC_N_EXT-1:0] external_interrupt_pin, // external pins, low active
  input wire logic [SCMC_N_EXT-1:0] ext_int_wake_enable, // pin wake enables
  input wire logic port_pin_wake, // other enabled pin wake event
  input wire logic irq_wake, // any enabled interrupt pending
  input wire logic watchdog_timer_enabled, // watchdog is enabled
  output logic cpu_clk_en, // CPU clock tick
  output logic periph_clk_en, // UART, timer0-2, ADC clock tick
  output logic timer3_clk_en, // Timer3 and pin logic clock tick
  output logic wdt_clk_en, // watchdog clock tick
  output logic fast_osc_enable, // fast oscillator run
  output logic slow_osc_enable, // slow oscillator run
  output logic fast_osc_type, // 1 fast crystal, 0 internal fast RC
  output logic slow_osc_type, // 1 slow crystal, 0 internal slow RC
  output logic divided_clock_output, // system clock divided by two
  output logic [1:0] mode // current operating mode
);
  scmc_system_clock_control_t clk_q;
  logic [7:0] pwr_q;
  logic [7:0] auxiliary_control_two_q;
  logic [7:0] ckout_q;
  scmc_state_t state_q;
  logic [SCMC_N_EXT+1:0] sync_lv;
  logic [1:0] osc_prev_q;
  logic fast_edge;
  logic slow_edge;
  logic src_tick;
  logic sys_tick;
  logic pin_block;
  logic stop_wake;
  logic idle_wake;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic hit;
  scmc_system_clock_control_t wclk;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic cpu_clk_en_q;
  logic periph_clk_en_q;
  logic timer3_clk_en_q;
  logic wdt_clk_en_q;
  logic fast_osc_enable_q;
  logic slow_osc_enable_q;
  logic divided_clock_output_q;
  logic [1:0] mode_q;

  scmc_sync #(
    .WIDTH(SCMC_N_EXT + 2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({external_interrupt_pin, slow_osc_in, fast_osc_in}),
    .sync_out(sync_lv)
  );

  // Edge detect reads only the second synchroniser stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q <= 2'b00;
    end else begin
      osc_prev_q <= sync_lv[1:0];
    end
  end

  assign fast_edge = sync_lv[0] & ~osc_prev_q[0] & fast_osc_enable_q;
  assign slow_edge = sync_lv[1] & ~osc_prev_q[1] & slow_osc_enable_q;
  // No source ticks in Stop, so every prescaled tick halts; only the watchdog tick runs on, from slow_edge
  assign src_tick = (state_q != SCMC_STOP) &
                    (clk_q.system_clock_source_sel ? fast_edge : slow_edge);

  scmc_prescaler #(
    .CNT_W(SCMC_PSC_W)
  ) u_psc (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .psc_code(clk_q.system_clock_prescale),
    .sys_tick_q(sys_tick)
  );

  assign pin_block = |(~sync_lv[SCMC_N_EXT+1:2] & ext_int_wake_enable);
  assign stop_wake = pin_block | port_pin_wake;
  assign idle_wake = irq_wake;

  // APB decode; write lands at the edge where pready is sampled high
  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign wr_en = psel & penable & pready_q & pwrite & hit;
  assign wclk = scmc_system_clock_control_t'(wbyte);

  always_comb begin
    hit = 1'b1;
    rbyte = 8'h00;
    if (paddr[SCMC_ADDR_W-1:10] != '0 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (idx == SCMC_IDX_PWR) begin
      rbyte = pwr_q;
    end else if (idx == SCMC_IDX_CLK) begin
      rbyte = clk_q;
      rbyte[5] = 1'b0;
    end else if (idx == SCMC_IDX_AUXILIARY_CONTROL_TWO) begin
      rbyte = auxiliary_control_two_q;
    end else if (idx == SCMC_IDX_CKOUT) begin
      rbyte = ckout_q;
    end else if (idx == SCMC_IDX_STATUS) begin
      rbyte = {6'h00, mode_q};
    end else begin
      hit = 1'b0;
    end
  end

  // One wait-free access phase: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      if (psel && !penable) begin
        prdata_q <= {24'h00_0000, rbyte};
      end
    end
  end

  // Type, stop and select fields check the state before the write, so illegal changes simply keep the old value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= scmc_system_clock_control_t'(SCMC_CLK_RESET);
    end else if (wr_en && idx == SCMC_IDX_CLK) begin
      clk_q.system_clock_prescale <= wclk.system_clock_prescale;
      clk_q.peripheral_clock_stop_idle <= wclk.peripheral_clock_stop_idle;
      if (clk_q.system_clock_source_sel) begin
        clk_q.slow_clock_type_sel <= wclk.slow_clock_type_sel;
      end
      if (!clk_q.system_clock_source_sel) begin
        clk_q.fast_clock_type_sel <= wclk.fast_clock_type_sel;
        clk_q.fast_clock_stop <= wclk.fast_clock_stop;
      end
      // Only old stop bit 1 blocks selecting a stopped fast clock; a combined stop-and-select write from Slow sets both
      if (!clk_q.fast_clock_stop) begin
        clk_q.system_clock_source_sel <= wclk.system_clock_source_sel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auxiliary_control_two_q <= SCMC_AUXILIARY_CONTROL_TWO_RESET;
      ckout_q <= SCMC_CKOUT_RESET;
    end else if (wr_en) begin
      if (idx == SCMC_IDX_AUXILIARY_CONTROL_TWO) begin
        auxiliary_control_two_q <= (auxiliary_control_two_q & ~SCMC_AUXILIARY_CONTROL_TWO_WMASK) | (wbyte & SCMC_AUXILIARY_CONTROL_TWO_WMASK);
      end
      if (idx == SCMC_IDX_CKOUT) begin
        ckout_q <= {7'h00, wbyte[0]};
      end
    end
  end

  // Power-mode register and state machine; request bits clear on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= SCMC_PWR_RESET;
      state_q <= SCMC_RUN;
    end else begin
      case (state_q)
        SCMC_RUN: begin
          if (wr_en && idx == SCMC_IDX_PWR) begin
            pwr_q <= wbyte & SCMC_PWR_WMASK;
            if (wbyte[SCMC_PWR_STOP_BIT] && pin_block) begin
              pwr_q[SCMC_PWR_STOP_BIT] <= 1'b0;
              if (wbyte[SCMC_PWR_IDLE_BIT]) begin
                state_q <= SCMC_IDLE;
              end
            end else if (wbyte[SCMC_PWR_STOP_BIT]) begin
              state_q <= SCMC_STOP;
            end else if (wbyte[SCMC_PWR_IDLE_BIT]) begin
              state_q <= SCMC_IDLE;
            end
          end
        end
        SCMC_IDLE: begin
          if (idle_wake) begin
            state_q <= SCMC_RUN;
            pwr_q[SCMC_PWR_IDLE_BIT] <= 1'b0;
          end
        end
        SCMC_STOP: begin
          if (stop_wake) begin
            state_q <= SCMC_RUN;
            pwr_q[SCMC_PWR_STOP_BIT] <= 1'b0;
            pwr_q[SCMC_PWR_IDLE_BIT] <= 1'b0;
          end
        end
        default: begin
          state_q <= SCMC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= SCMC_MODE_SLOW;
    end else begin
      case (state_q)
        SCMC_IDLE: mode_q <= SCMC_MODE_IDLE;
        SCMC_STOP: mode_q <= SCMC_MODE_STOP;
        default: mode_q <= clk_q.system_clock_source_sel ? SCMC_MODE_FAST : SCMC_MODE_SLOW;
      endcase
    end
  end

  // Clock gating ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en_q <= 1'b0;
      periph_clk_en_q <= 1'b0;
      timer3_clk_en_q <= 1'b0;
      wdt_clk_en_q <= 1'b0;
    end else begin
      cpu_clk_en_q <= sys_tick & (state_q == SCMC_RUN);
      periph_clk_en_q <= sys_tick & ~(state_q == SCMC_IDLE && clk_q.peripheral_clock_stop_idle);
      timer3_clk_en_q <= sys_tick;
      // Watchdog keeps the slow oscillator beat in Stop
      wdt_clk_en_q <= (state_q == SCMC_STOP) ? (watchdog_timer_enabled & slow_edge) : sys_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_enable_q <= 1'b0;
      slow_osc_enable_q <= 1'b1;
    end else begin
      fast_osc_enable_q <= ~clk_q.fast_clock_stop & (state_q != SCMC_STOP);
      slow_osc_enable_q <= (state_q != SCMC_STOP) | watchdog_timer_enabled;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divided_clock_output_q <= 1'b0;
    end else if (!ckout_q[0]) begin
      divided_clock_output_q <= 1'b0;
    end else if (sys_tick) begin
      divided_clock_output_q <= ~divided_clock_output_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_clk_en = cpu_clk_en_q;
  assign periph_clk_en = periph_clk_en_q;
  assign timer3_clk_en = timer3_clk_en_q;
  assign wdt_clk_en = wdt_clk_en_q;
  assign fast_osc_enable = fast_osc_enable_q;
  assign slow_osc_enable = slow_osc_enable_q;
  assign fast_osc_type = clk_q.fast_clock_type_sel;
  assign slow_osc_type = clk_q.slow_clock_type_sel;
  assign divided_clock_output = divided_clock_output_q;
  assign mode = mode_q;
endmodule

// ==== tb/scmc_top_checker.sv ====
// Concurrent checks of mode changes and clock gating.
// Assumes it is bound to scmc_top and sees its ports only.
`timescale 1ns/1ns
module scmc_top_checker
  import scmc_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB write
  input wire logic pready, // APB ready
  input wire logic [SCMC_ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [SCMC_N_EXT-1:0] external_interrupt_pin, // pins, low active
  input wire logic [SCMC_N_EXT-1:0] ext_int_wake_enable, // pin enables
  input wire logic port_pin_wake, // other pin wake
  input wire logic irq_wake, // interrupt pending
  input wire logic watchdog_timer_enabled, // watchdog on
  input wire logic cpu_clk_en, // CPU tick
  input wire logic periph_clk_en, // peripheral tick
  input wire logic timer3_clk_en, // Timer3 tick
  input wire logic fast_osc_enable, // fast osc run
  input wire logic slow_osc_enable, // slow osc run
  input wire logic [1:0] mode // mode code
);
  wire logic pwr_wr;
  wire logic pin_req;
  wire logic stopped;
  assign pwr_wr = psel && penable && pready && pwrite && paddr == {2'b00, SCMC_IDX_PWR, 2'b00};
  assign pin_req = |(~external_interrupt_pin & ext_int_wake_enable);
  assign stopped = mode == SCMC_MODE_STOP;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_stop_gates_ticks: assert property (stopped[*2] |-> !cpu_clk_en && !periph_clk_en && !timer3_clk_en)
    else $error("tick seen in stop mode");
  a_stop_fast_off: assert property (stopped[*2] |-> !fast_osc_enable)
    else $error("fast oscillator runs in stop mode");
  a_stop_slow_off: assert property ((stopped && !watchdog_timer_enabled)[*3] |-> !slow_osc_enable)
    else $error("slow oscillator runs in stop without watchdog");
  a_run_slow_on: assert property ((mode == SCMC_MODE_SLOW || mode == SCMC_MODE_FAST)[*2] |-> slow_osc_enable)
    else $error("slow oscillator off while running");
  a_idle_cpu_halt: assert property ((mode == SCMC_MODE_IDLE)[*2] |-> !cpu_clk_en)
    else $error("CPU tick seen in idle mode");
  a_idle_entry: assert property (pwr_wr && pwdata[1:0] == 2'b01 && !irq_wake |-> ##[1:3] mode == SCMC_MODE_IDLE)
    else $error("idle not entered");
  a_idle_exit: assert property (mode == SCMC_MODE_IDLE && irq_wake |-> ##[1:2] mode != SCMC_MODE_IDLE)
    else $error("idle not left on interrupt");
  a_stop_entry: assert property (((!pin_req && !port_pin_wake)[*4] ##0 (pwr_wr && pwdata[1])) |-> ##[1:3] stopped)
    else $error("stop not entered");
  a_stop_refused: assert property ((pin_req[*4] ##0 (pwr_wr && pwdata[1])) |-> ##1 (!stopped)[*3])
    else $error("stop entered with enabled pin low");
  a_stop_holds: assert property ((stopped && !pin_req && !port_pin_wake)[*4] |=> stopped)
    else $error("stop left without pin wake");
endmodule

bind scmc_top scmc_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata), .external_interrupt_pin(external_interrupt_pin),
  .ext_int_wake_enable(ext_int_wake_enable), .port_pin_wake(port_pin_wake), .irq_wake(irq_wake),
  .watchdog_timer_enabled(watchdog_timer_enabled), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .timer3_clk_en(timer3_clk_en), .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable), .mode(mode));

// ==== tb/scmc_top_tb.sv ====
// Self-checking bench of the clock and power-mode controller.
// Drives APB, oscillator levels and wake pins itself; no partner model.
`timescale 1ns/1ns
module scmc_top_tb;
  import scmc_pkg::*;
  localparam logic [11:0] A_PWR = {2'b00, SCMC_IDX_PWR, 2'b00};
  localparam logic [11:0] A_CLK = {2'b00, SCMC_IDX_CLK, 2'b00};
  localparam logic [11:0] A_AUX = {2'b00, SCMC_IDX_AUXILIARY_CONTROL_TWO, 2'b00};
  localparam logic [11:0] A_CKO = {2'b00, SCMC_IDX_CKOUT, 2'b00};
  localparam logic [11:0] A_STS = {2'b00, SCMC_IDX_STATUS, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fast_osc_in = 1'b0;
  logic slow_osc_in = 1'b0;
  logic port_pin_wake = 1'b0;
  logic irq_wake = 1'b0;
  logic watchdog_timer_enabled = 1'b0;
  logic [2:0] external_interrupt_pin = 3'h7;
  logic [2:0] ext_int_wake_enable = 3'h0;
  logic [3:0] oc = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_clk_en, periph_clk_en, timer3_clk_en, wdt_clk_en;
  logic fast_osc_enable, slow_osc_enable, fast_osc_type, slow_osc_type, divided_clock_output, pv;
  logic [1:0] mode;
  logic [7:0] rd;
  logic er;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_cpu, n_per, n_t3, n_wdt, n_tog, p;

  scmc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_osc_in(fast_osc_in),
    .slow_osc_in(slow_osc_in), .external_interrupt_pin(external_interrupt_pin), .ext_int_wake_enable(ext_int_wake_enable),
    .port_pin_wake(port_pin_wake), .irq_wake(irq_wake), .watchdog_timer_enabled(watchdog_timer_enabled),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .timer3_clk_en(timer3_clk_en), .wdt_clk_en(wdt_clk_en),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable), .fast_osc_type(fast_osc_type),
    .slow_osc_type(slow_osc_type), .divided_clock_output(divided_clock_output), .mode(mode));

  always #5 pclk = ~pclk;

  // Fast source rises every 4 cycles, slow every 16, so periods are exact
  always @(posedge pclk) begin
    oc <= oc + 4'h1;
    fast_osc_in <= oc[1];
    slow_osc_in <= oc[3];
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    chk({15'h0, c}, 16'h0001);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Request held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count assumed; only the run timeout ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({8'h00, rd}, {8'h00, e});
  endtask

  task automatic run(input int n);
    n_cpu = 0; n_per = 0; n_t3 = 0; n_wdt = 0; n_tog = 0;
    pv = divided_clock_output;
    repeat (n) begin
      @(posedge pclk);
      n_cpu += int'(cpu_clk_en === 1'b1);
      n_per += int'(periph_clk_en === 1'b1);
      n_t3 += int'(timer3_clk_en === 1'b1);
      n_wdt += int'(wdt_clk_en === 1'b1);
      n_tog += int'(divided_clock_output !== pv);
      pv = divided_clock_output;
    end
  endtask

  task automatic period;
    int n;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 600) begin
      @(posedge pclk);
      n++;
    end
    p = 0;
    do begin
      @(posedge pclk);
      p++;
    end while (cpu_clk_en !== 1'b1 && p < 600);
  endtask

  task automatic t_reset;
    rdc(A_PWR, SCMC_PWR_RESET);
    rdc(A_CLK, 8'h03);
    rdc(A_STS, 8'h00);
    rdc(A_AUX, 8'h0E);
    rdc(A_CKO, 8'h00);
    ok(slow_osc_type === 1'b0);
    apb(1'b0, 12'h100, 8'h00);
    ok(er === 1'b1 && rd === 8'h00);
    apb(1'b1, A_AUX, 8'h00);
    rdc(A_AUX, 8'h02);
    $display("test reset finished");
  endtask

  task automatic t_prescale;
    int dv[4] = '{16, 4, 2, 1};
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_CLK, 8'(c));
      // Adoption takes up to 16 source ticks, with no odd period under the old or new code
      wt(16 * 18 + 8);
      period();
      chk(16'(p), 16'(16 * dv[c]));
    end
    $display("test prescale finished");
  endtask

  task automatic t_clkctl;
    // Never stop and source select set together
    logic [7:0] cw[9] = '{8'h83, 8'h43, 8'h47, 8'h07, 8'hC7, 8'hC3, 8'hCB, 8'hC7, 8'h03};
    logic [7:0] ce[9] = '{8'h03, 8'h43, 8'h47, 8'h47, 8'hC7, 8'hC3, 8'hCB, 8'hC3, 8'h83};
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, A_CLK, cw[i]);
      rdc(A_CLK, ce[i]);
      wt(4);
      if (i == 1)
        ok(fast_osc_type === 1'b1);
      if (i == 2)
        chk({14'h0, mode}, 16'h0001);
      if (i == 4)
        ok(slow_osc_type === 1'b1);
      if (i == 6)
        ok(fast_osc_enable === 1'b0);
    end
    $display("test clock control finished");
  endtask

  task automatic t_idle;
    apb(1'b1, A_PWR, 8'h01);
    wt(4);
    chk({14'h0, mode}, 16'h0002);
    run(200);
    ok(n_cpu == 0 && n_per > 0);
    irq_wake <= 1'b1;
    wt(3);
    chk({14'h0, mode}, 16'h0000);
    irq_wake <= 1'b0;
    rdc(A_PWR, 8'h00);
    apb(1'b1, A_CLK, 8'h93);
    apb(1'b1, A_PWR, 8'h01);
    // Tick launched in the write cycle still comes from Run
    wt(2);
    run(200);
    ok(n_per == 0 && n_t3 > 0);
    irq_wake <= 1'b1;
    wt(3);
    irq_wake <= 1'b0;
    apb(1'b1, A_CLK, 8'h83);
    $display("test idle finished");
  endtask

  task automatic t_stop;
    ext_int_wake_enable <= 3'b010;
    external_interrupt_pin <= 3'b101;
    wt(5);
    apb(1'b1, A_PWR, 8'h02);
    wt(4);
    rdc(A_PWR, 8'h00);
    external_interrupt_pin <= 3'b111;
    wt(5);
    apb(1'b1, A_PWR, 8'h02);
    wt(4);
    chk({14'h0, mode}, 16'h0003);
    ok(fast_osc_enable === 1'b0 && slow_osc_enable === 1'b0);
    irq_wake <= 1'b1;
    run(100);
    ok(n_cpu + n_per + n_t3 + n_wdt == 0);
    chk({14'h0, mode}, 16'h0003);
    irq_wake <= 1'b0;
    external_interrupt_pin <= 3'b101;
    wt(8);
    chk({14'h0, mode}, 16'h0000);
    external_interrupt_pin <= 3'b111;
    watchdog_timer_enabled <= 1'b1;
    wt(5);
    apb(1'b1, A_PWR, 8'h02);
    run(100);
    ok(slow_osc_enable === 1'b1 && n_wdt > 0);
    port_pin_wake <= 1'b1;
    wt(4);
    chk({14'h0, mode}, 16'h0000);
    port_pin_wake <= 1'b0;
    watchdog_timer_enabled <= 1'b0;
    $display("test stop finished");
  endtask

  task automatic t_clkout;
    apb(1'b1, A_CKO, 8'h01);
    run(200);
    ok(n_t3 > 0 && n_tog >= n_t3 - 1 && n_tog <= n_t3 + 1);
    apb(1'b1, A_CKO, 8'h00);
    wt(3);
    ok(divided_clock_output === 1'b0);
    $display("test clock output finished");
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prescale();
    t_clkctl();
    t_idle();
    t_stop();
    t_clkout();
    wrap_up();
  end
endmodule
